// ### verilog/lpm_defines.vh
`ifndef LPM_DEFINES_VH
`define LPM_DEFINES_VH
// Register byte offsets
`define LPM_OFF_DYNREF    12'h008
`define LPM_OFF_SLEEP     12'h010
`define LPM_OFF_PWRSAVE   12'h084
`define LPM_OFF_TIMEOUT   12'h100
`define LPM_OFF_STATUS    12'h104
`define LPM_OFF_MEMTYPE   12'h108
// Field positions
`define LPM_BIT_SELFREF   5
`define LPM_BIT_DEEP      0
`define LPM_BIT_PRECHG    1
`define LPM_BIT_CLKHALT   0
`define LPM_BIT_LPDDR1    0
// Reset values: every allow bit clear
`define LPM_RST_DYNREF    32'h00000C88
`define LPM_RST_SLEEP     32'h00000000
`define LPM_RST_PWRSAVE   32'h00000414
`define LPM_RST_TIMEOUT   32'h00000010
`define LPM_RST_MEMTYPE   32'h00000001
// Idle timeout is counted in units of 32 clocks
`define LPM_TO_UNIT       32'h00000020
// Init sequence length after deep sleep exit, in cycles
`define LPM_INIT_CYCLES   16'h0040
// AXI responses
`define LPM_RESP_OKAY     2'h0
`define LPM_RESP_SLVERR   2'h2
`endif

// ### verilog/lpm_axil_slave.v
`timescale 1ns/1ns
`include "lpm_defines.vh"
// AXI4-Lite register slave for the low-power manager
module lpm_axil_slave (
	input  wire        clk,
	input  wire        rstn,
	input  wire [11:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [11:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire [31:0] statusWord,
	output wire [31:0] dynRefWord,
	output wire [31:0] sleepWord,
	output wire [31:0] pwrSaveWord,
	output wire [31:0] timeoutWord,
	output wire [31:0] memTypeWord
);
	reg        awHeld_ff;    // Write address captured
	reg [11:0] awAddr_ff;
	reg        wHeld_ff;     // Write data captured
	reg [31:0] wData_ff;
	reg [3:0]  wStrb_ff;
	reg        bValid_ff;
	reg [1:0]  bResp_ff;
	reg        rValid_ff;
	reg [31:0] rData_ff;
	reg [1:0]  rResp_ff;
	reg [31:0] dynRef_ff;
	reg [31:0] sleep_ff;
	reg [31:0] pwrSave_ff;
	reg [31:0] timeout_ff;
	reg [31:0] memType_ff;
	wire       doWrite;
	reg        wrHit;
	reg [31:0] rdMux;
	reg        rdHit;

	// Address and data accepted in either order, one write at a time
	assign s_axi_awready = !awHeld_ff && !bValid_ff;
	assign s_axi_wready  = !wHeld_ff && !bValid_ff;
	assign s_axi_arready = !rValid_ff;
	assign s_axi_bvalid  = bValid_ff;
	assign s_axi_bresp   = bResp_ff;
	assign s_axi_rvalid  = rValid_ff;
	assign s_axi_rdata   = rData_ff;
	assign s_axi_rresp   = rResp_ff;
	assign doWrite = awHeld_ff && wHeld_ff && !bValid_ff;
	assign dynRefWord  = dynRef_ff;
	assign sleepWord   = sleep_ff;
	assign pwrSaveWord = pwrSave_ff;
	assign timeoutWord = timeout_ff;
	assign memTypeWord = memType_ff;

	// Byte-lane merge helper
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  strb;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i]) begin
					merge[i*8 +: 8] = nw[i*8 +: 8];
				end
			end
		end
	endfunction

	// Write decode
	always @* begin
		case (awAddr_ff)
			`LPM_OFF_DYNREF, `LPM_OFF_SLEEP, `LPM_OFF_PWRSAVE,
			`LPM_OFF_TIMEOUT, `LPM_OFF_MEMTYPE: wrHit = 1'b1;
			default: wrHit = 1'b0;
		endcase
	end

	// Read decode; status is read-only
	always @* begin
		rdHit = 1'b1;
		// Low address bits ignored, as on the write side
		case ({s_axi_araddr[11:2], 2'b00})
			`LPM_OFF_DYNREF:  rdMux = dynRef_ff;
			`LPM_OFF_SLEEP:   rdMux = sleep_ff;
			`LPM_OFF_PWRSAVE: rdMux = pwrSave_ff;
			`LPM_OFF_TIMEOUT: rdMux = timeout_ff;
			`LPM_OFF_STATUS:  rdMux = statusWord;
			`LPM_OFF_MEMTYPE: rdMux = memType_ff;
			default: begin
				rdMux = 32'h00000000;
				rdHit = 1'b0;
			end
		endcase
	end

	// Write channel and register storage
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			awHeld_ff  <= 1'b0;
			awAddr_ff  <= 12'h000;
			wHeld_ff   <= 1'b0;
			wData_ff   <= 32'h00000000;
			wStrb_ff   <= 4'h0;
			bValid_ff  <= 1'b0;
			bResp_ff   <= `LPM_RESP_OKAY;
			dynRef_ff  <= `LPM_RST_DYNREF;   // [RQ17]
			sleep_ff   <= `LPM_RST_SLEEP;    // [RQ17]
			pwrSave_ff <= `LPM_RST_PWRSAVE;  // [RQ17]
			timeout_ff <= `LPM_RST_TIMEOUT;
			memType_ff <= `LPM_RST_MEMTYPE;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_ff <= 1'b1;
				awAddr_ff <= {s_axi_awaddr[11:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_ff <= 1'b1;
				wData_ff <= s_axi_wdata;
				wStrb_ff <= s_axi_wstrb;
			end
			if (doWrite) begin
				awHeld_ff <= 1'b0;
				wHeld_ff  <= 1'b0;
				bValid_ff <= 1'b1;
				bResp_ff  <= wrHit ? `LPM_RESP_OKAY : `LPM_RESP_SLVERR;
				// Fabric master steers each allow bit here [RQ13]
				case (awAddr_ff)
					`LPM_OFF_DYNREF:  dynRef_ff  <= merge(dynRef_ff, wData_ff, wStrb_ff);
					`LPM_OFF_SLEEP:   sleep_ff   <= merge(sleep_ff, wData_ff, wStrb_ff);
					`LPM_OFF_PWRSAVE: pwrSave_ff <= merge(pwrSave_ff, wData_ff, wStrb_ff);
					`LPM_OFF_TIMEOUT: timeout_ff <= merge(timeout_ff, wData_ff, wStrb_ff);
					`LPM_OFF_MEMTYPE: memType_ff <= merge(memType_ff, wData_ff, wStrb_ff);
					default: ;
				endcase
			end else if (bValid_ff && s_axi_bready) begin
				bValid_ff <= 1'b0;
			end
		end
	end

	// Read channel, one cycle to data
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rValid_ff <= 1'b0;
			rData_ff  <= 32'h00000000;
			rResp_ff  <= `LPM_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rValid_ff <= 1'b1;
			rData_ff  <= rdMux;
			rResp_ff  <= rdHit ? `LPM_RESP_OKAY : `LPM_RESP_SLVERR;
		end else if (rValid_ff && s_axi_rready) begin
			rValid_ff <= 1'b0;
		end
	end
endmodule

// ### verilog/lpm_idle_timer.v
`timescale 1ns/1ns
`include "lpm_defines.vh"
// Idle timer: counts x32 units while the controller stays idle
module lpm_idle_timer (
	input  wire        clk,
	input  wire        rstn,
	input  wire        run,
	input  wire [15:0] limitX32,
	output wire        expired
);
	reg [4:0]  subCnt_ff;   // Cycles within one x32 unit
	reg [15:0] unitCnt_ff;  // Whole units elapsed
	reg        done_ff;

	assign expired = done_ff;

	// Restart whenever activity drops run
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			subCnt_ff  <= 5'h00;
			unitCnt_ff <= 16'h0000;
			done_ff    <= 1'b0;
		end else if (!run) begin
			subCnt_ff  <= 5'h00;
			unitCnt_ff <= 16'h0000;
			done_ff    <= 1'b0;
		end else if (!done_ff) begin
			subCnt_ff <= subCnt_ff + 5'h01;
			if (subCnt_ff == 5'h1F) begin
				unitCnt_ff <= unitCnt_ff + 16'h0001;
			end
			// A zero limit still waits one unit
			if (subCnt_ff == 5'h1F && unitCnt_ff + 16'h0001 >= limitX32) begin
				done_ff <= 1'b1;
			end
		end
	end
endmodule

// ### verilog/lpm_power_manager.v
// Function
// RQ1 - Self-refresh entered when requested and idle
// RQ2 - Self-refresh left on withdrawal or new request
// RQ3 - Precharge sleep after programmed idle timeout
// RQ4 - Precharge sleep keeps only clock-enable driven
// RQ5 - Precharge sleep exits: refresh, request, disallow
// RQ6 - Deep sleep only for first-generation LPDDR
// RQ7 - Deep sleep entered when allowed and idle
// RQ8 - No refresh in deep sleep; data lost
// RQ9 - Deep sleep disallow exits and reinitialises memory
// RQ10 - Clock halt only for first-generation LPDDR
// RQ11 - Clock halts when allowed and idle
// RQ12 - Clock restarts when halt disallowed
// RQ13 - Fabric master writes allow bits over bus
// RQ14 - Combined word: bit0 deep, bit1 precharge
// RQ15 - Power-save word bit0 allows clock halt
// RQ16 - Dynamic refresh word bit5 requests self-refresh
// RQ17 - All allow bits clear after reset
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "lpm_defines.vh"
module lpm_power_manager (
	input  wire        clk,
	input  wire        rstn,
	input  wire [11:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [11:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        coreRequest,
	input  wire        opsPending,
	input  wire        refreshDue,
	input  wire        initDone,
	output wire        coreGrant,
	output wire        refreshGrant,
	output wire        memIoEnable,
	output wire        memClkEnable,
	output wire        memCke,
	output wire        selfRefreshCmd,
	output wire        deepSleepCmd,
	output wire        initStart,
	output wire [5:0]  lpState
);
	// One-hot power states
	localparam [5:0] ST_ACTIVE  = 6'h01;
	localparam [5:0] ST_SELFREF = 6'h02;
	localparam [5:0] ST_PRECHG  = 6'h04;
	localparam [5:0] ST_DEEP    = 6'h08;
	localparam [5:0] ST_CLKHALT = 6'h10;
	localparam [5:0] ST_REINIT  = 6'h20;

	wire [31:0] dynRefWord;     // Dynamic refresh config word
	wire [31:0] sleepWord;      // Combined sleep config word
	wire [31:0] pwrSaveWord;    // Power save config word
	wire [31:0] timeoutWord;    // Sleep idle timeout
	wire [31:0] memTypeWord;    // Bit0 set: first-generation LPDDR
	wire [31:0] statusWord;     // State readback
	wire        selfRefreshRequestBit;
	wire        prechargeSleepAllow;
	wire        deepSleepAllow;
	wire        memoryClockHaltAllow;
	wire        isLpddr1;
	wire        idleNow;
	wire        timerExpired;
	reg  [5:0]  state_ff;
	reg  [5:0]  nxt_state;
	reg  [15:0] initCnt_ff;     // Reinit sequence cycles
	reg  [15:0] nxt_initCnt;
	reg         initStart_ff;
	reg         nxt_initStart;
	reg         dataLost_ff;    // Sticky: contents gone after deep sleep
	reg         nxt_dataLost;

	// Register slave
	lpm_axil_slave uBus (
		.clk           (clk),
		.rstn          (rstn),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.statusWord    (statusWord),
		.dynRefWord    (dynRefWord),
		.sleepWord     (sleepWord),
		.pwrSaveWord   (pwrSaveWord),
		.timeoutWord   (timeoutWord),
		.memTypeWord   (memTypeWord)
	);

	// Field extraction
	assign selfRefreshRequestBit = dynRefWord[`LPM_BIT_SELFREF];    // [RQ16]
	assign deepSleepAllow        = sleepWord[`LPM_BIT_DEEP];        // [RQ14]
	assign prechargeSleepAllow   = sleepWord[`LPM_BIT_PRECHG];      // [RQ14]
	assign memoryClockHaltAllow  = pwrSaveWord[`LPM_BIT_CLKHALT];   // [RQ15]
	assign isLpddr1              = memTypeWord[`LPM_BIT_LPDDR1];

	// Idle means nothing queued and nothing new arriving
	assign idleNow = !opsPending && !coreRequest;

	// Timer only runs while active, idle and sleep allowed
	lpm_idle_timer uTimer (
		.clk      (clk),
		.rstn     (rstn),
		.run      (state_ff == ST_ACTIVE && idleNow && prechargeSleepAllow),
		.limitX32 (timeoutWord[15:0]),
		.expired  (timerExpired)
	);

	// Next-state logic; deeper savings take priority on entry
	always @* begin
		nxt_state     = state_ff;
		nxt_initCnt   = initCnt_ff;
		nxt_initStart = 1'b0;
		nxt_dataLost  = dataLost_ff;
		case (state_ff)
			ST_ACTIVE: begin
				if (deepSleepAllow && isLpddr1 && idleNow) begin // [RQ6] [RQ7]
					nxt_state    = ST_DEEP;
					nxt_dataLost = 1'b1;                           // [RQ8]
				end else if (selfRefreshRequestBit && idleNow) begin // [RQ1]
					nxt_state = ST_SELFREF;
				end else if (memoryClockHaltAllow && isLpddr1 && idleNow) begin // [RQ10] [RQ11]
					nxt_state = ST_CLKHALT;
				end else if (timerExpired && idleNow && !refreshDue) begin // [RQ3]
					nxt_state = ST_PRECHG;
				end
			end
			ST_SELFREF: begin
				// Memory refreshes itself; leave on withdrawal or traffic
				if (!selfRefreshRequestBit || coreRequest) begin   // [RQ2]
					nxt_state = ST_ACTIVE;
				end
			end
			ST_PRECHG: begin
				if (refreshDue || coreRequest || !prechargeSleepAllow) begin // [RQ5]
					nxt_state = ST_ACTIVE;
				end
			end
			ST_DEEP: begin
				// Requests wait: only clearing the allow bit wakes it
				if (!deepSleepAllow) begin                          // [RQ9]
					nxt_state     = ST_REINIT;
					nxt_initCnt   = `LPM_INIT_CYCLES;
					nxt_initStart = 1'b1;
				end
			end
			ST_CLKHALT: begin
				// Requests wait until the halt is disallowed
				if (!memoryClockHaltAllow) begin                    // [RQ12]
					nxt_state = ST_ACTIVE;
				end
			end
			ST_REINIT: begin
				// Minimum init window, then wait for the init engine
				if (initCnt_ff != 16'h0000) begin
					nxt_initCnt = initCnt_ff - 16'h0001;
				end else if (initDone) begin                       // [RQ9]
					nxt_state    = ST_ACTIVE;
					nxt_dataLost = 1'b0;
				end
			end
			default: begin
				nxt_state = ST_ACTIVE;
			end
		endcase
	end

	// State registers
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_ff     <= ST_ACTIVE;
			initCnt_ff   <= 16'h0000;
			initStart_ff <= 1'b0;
			dataLost_ff  <= 1'b0;
		end else begin
			state_ff     <= nxt_state;
			initCnt_ff   <= nxt_initCnt;
			initStart_ff <= nxt_initStart;
			dataLost_ff  <= nxt_dataLost;
		end
	end

	// Core traffic only flows while fully active
	assign coreGrant    = (state_ff == ST_ACTIVE);
	// No refresh issued from deep sleep, self-refresh or reinit
	assign refreshGrant = (state_ff == ST_ACTIVE) || (state_ff == ST_PRECHG && refreshDue); // [RQ8]
	// Only clock-enable stays driven in precharge and deep sleep
	assign memIoEnable  = !(state_ff == ST_PRECHG || state_ff == ST_DEEP ||
		state_ff == ST_SELFREF);                                      // [RQ4]
	assign memClkEnable = !(state_ff == ST_CLKHALT);                    // [RQ11]
	// CKE low in every power-down style state except clock halt
	assign memCke       = (state_ff == ST_ACTIVE || state_ff == ST_CLKHALT ||
		state_ff == ST_REINIT);
	assign selfRefreshCmd = (state_ff == ST_SELFREF);
	assign deepSleepCmd   = (state_ff == ST_DEEP);
	assign initStart      = initStart_ff;
	assign lpState        = state_ff;
	// Status readback: state bits plus data-lost flag
	assign statusWord     = {23'h000000, dataLost_ff, 2'b00, state_ff};
endmodule

// ### dv/lpm_power_props.sv
`timescale 1ns/1ns
// State and pin relations of the power manager
module lpm_power_props (
	input wire logic       clk,
	input wire logic       rstn,
	input wire logic       coreRequest,
	input wire logic       opsPending,
	input wire logic       refreshDue,
	input wire logic       refreshGrant,
	input wire logic       memIoEnable,
	input wire logic       memClkEnable,
	input wire logic       memCke,
	input wire logic       initStart,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic [5:0] lpState
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (!rstn);
	// Deep sleep left for reinit
	sequence deepToInit;
		lpState == 6'h08 ##1 lpState == 6'h20;
	endsequence
	// Busy controller seen while active
	sequence busyActive;
		lpState == 6'h01 && (opsPending || coreRequest);
	endsequence
	prechgPins_a: assert property (lpState == 6'h04 |-> !memIoEnable && !memCke)
		else $error("io left on in precharge sleep");
	deepNoRefresh_a: assert property (lpState == 6'h08 |-> !refreshGrant && !memCke)
		else $error("refresh granted in deep sleep");
	srExit_a: assert property (lpState == 6'h02 && coreRequest |=> lpState == 6'h01)
		else $error("self refresh kept on request");
	prechgExit_a: assert property (lpState == 6'h04 && (refreshDue || coreRequest) |=> lpState == 6'h01)
		else $error("precharge sleep kept on wake cause");
	busyStay_a: assert property (busyActive |=> lpState == 6'h01)
		else $error("sleep entered while busy");
	initPulse_a: assert property (deepToInit |-> initStart ##1 !initStart)
		else $error("init start not one pulse");
	clkHalt_a: assert property (lpState == 6'h10 |-> !memClkEnable && memCke)
		else $error("clock running in halt state");
	bvalidHold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
endmodule
bind lpm_power_manager lpm_power_props chk_u (.*);

// ### dv/lpm_sdram_model.sv
`timescale 1ns/1ns
// Memory side: refresh demand and slow wake after init
module lpm_sdram_model #(
	parameter int INIT_WAIT = 100
) (
	input wire logic  clk,
	input wire logic  rstn,
	input wire logic  initStart,
	input wire logic  refreshGrant,
	input wire logic  refKick,
	output wire logic refreshDue,
	output wire logic initDone
);
	logic      refDue_ff; // Pending refresh demand
	logic      initOk_ff; // Memory ready after init
	logic [9:0] wake_ff;  // Settling countdown
	assign refreshDue = refDue_ff;
	assign initDone   = initOk_ff;
	// Demand held until granted; wake slower than the init count
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			refDue_ff <= 1'b0;
			initOk_ff <= 1'b1;
			wake_ff   <= 10'h000;
		end else begin
			if (refKick)
				refDue_ff <= 1'b1;
			else if (refreshGrant)
				refDue_ff <= 1'b0;
			if (initStart) begin
				initOk_ff <= 1'b0;
				wake_ff   <= 10'(INIT_WAIT);
			end else if (wake_ff != 10'h000)
				wake_ff <= wake_ff - 10'h001;
			else
				initOk_ff <= 1'b1;
		end
	end
endmodule

// ### dv/tb_lpm_power_manager.sv
`timescale 1ns/1ns
`include "lpm_defines.vh"
module tb_lpm_power_manager;
	logic        clk, rstn, awv, wv, bready, arv, rready;
	logic        coreRequest, opsPending, refKick, refreshDue, initDone;
	logic        awready, wready, bvalid, arready, rvalid, refreshGrant, initStart;
	logic        memIoEnable, memClkEnable, memCke, coreGrant, srCmd, deepCmd;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd, v;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rr, br;
	logic [5:0]  lpState;
	int          errors, checks_done, c, k;
	lpm_power_manager dut_u (.clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .coreRequest(coreRequest), .opsPending(opsPending),
		.refreshDue(refreshDue), .initDone(initDone), .coreGrant(coreGrant),
		.refreshGrant(refreshGrant),
		.memIoEnable(memIoEnable), .memClkEnable(memClkEnable), .memCke(memCke),
		.selfRefreshCmd(srCmd), .deepSleepCmd(deepCmd), .initStart(initStart),
		.lpState(lpState));
	lpm_sdram_model #(.INIT_WAIT(100)) mem_u (.clk(clk), .rstn(rstn), .initStart(initStart),
		.refreshGrant(refreshGrant), .refKick(refKick), .refreshDue(refreshDue),
		.initDone(initDone));
	// Free-running 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Verdict and end of run
	task conclude;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chkW(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	task chkS(input logic [5:0] e);
		chkW("lpState", {26'h0, e}, {26'h0, lpState});
		// Grant and command flags follow the state code
		chkW("cmds", {29'h0, e == 6'h01, e == 6'h02, e == 6'h08},
			{29'h0, coreGrant, srCmd, deepCmd});
	endtask
	// Bounded wait for a state, cycles returned in c
	task waitSt(input logic [5:0] e, input int lim);
		for (c = 0; c < lim && lpState !== e; c++)
			@(negedge clk);
		if (c == lim) begin
			errors++;
			$display("MISMATCH wait lpState exp %h got %h", e, lpState);
			conclude;
		end
	endtask
	// Handshakes judged at the falling edge, acted on after the rising edge
	task axiWr(input logic [11:0] a, input logic [31:0] d);
		int n;
		logic ta, tw, tb;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(negedge clk);
			ta = awv && awready;
			tw = wv && wready;
			tb = bvalid && bready;
			if (tb)
				br = bresp;
			@(posedge clk);
			if (ta)
				awv <= 1'b0;
			if (tw)
				wv <= 1'b0;
			if (tb) begin
				bready <= 1'b0;
				break;
			end
		end
		if (n == 100) begin
			errors++;
			$display("MISMATCH write handshake exp done got hung");
			conclude;
		end
	endtask
	task rdChk(input logic [11:0] a, input logic [31:0] e);
		int n;
		@(posedge clk);
		araddr <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 100 && !(rvalid && rready); n++) begin
			@(negedge clk);
			if (arv && arready) begin
				@(posedge clk);
				arv <= 1'b0;
				@(negedge clk);
			end
		end
		rd = rdata;
		rr = rresp;
		@(posedge clk);
		rready <= 1'b0;
		if (n == 100) begin
			errors++;
			$display("MISMATCH read handshake exp done got hung");
			conclude;
		end
		chkW($sformatf("reg %h", a), e, rd);
	endtask
	// Watchdog for a hung run
	initial begin
		#200000;
		errors++;
		$display("MISMATCH watchdog exp done got hung");
		conclude;
	end
	initial begin
		{rstn, awv, wv, bready, arv, rready, coreRequest, opsPending, refKick} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		c = $urandom(35);
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		rdChk(`LPM_OFF_DYNREF, `LPM_RST_DYNREF);
		rdChk(`LPM_OFF_SLEEP, `LPM_RST_SLEEP);
		rdChk(`LPM_OFF_PWRSAVE, `LPM_RST_PWRSAVE);
		rdChk(12'h0FC, 32'h00000000);
		chkW("rresp", {30'h0, `LPM_RESP_SLVERR}, {30'h0, rr});
		// Unmapped write refused; byte strobe honoured on a mapped one
		axiWr(12'h0FC, 32'hFFFFFFFF);
		chkW("bresp", {30'h0, `LPM_RESP_SLVERR}, {30'h0, br});
		wstrb <= 4'h2;
		axiWr(`LPM_OFF_TIMEOUT, 32'h0000FF00);
		wstrb <= 4'hF;
		chkW("bresp", {30'h0, `LPM_RESP_OKAY}, {30'h0, br});
		rdChk(`LPM_OFF_TIMEOUT, `LPM_RST_TIMEOUT | 32'h0000FF00);
		chkW("rresp", {30'h0, `LPM_RESP_OKAY}, {30'h0, rr});
		chkS(6'h01);
		$display("test reset done");
		// Self refresh waits for idle, leaves on request and withdrawal
		opsPending <= 1'b1;
		axiWr(`LPM_OFF_DYNREF, 32'h00000CA8);
		repeat (10) @(posedge clk);
		chkS(6'h01);
		opsPending <= 1'b0;
		waitSt(6'h02, 10);
		chkS(6'h02);
		@(posedge clk);
		coreRequest <= 1'b1;
		waitSt(6'h01, 4);
		chkS(6'h01);
		@(posedge clk);
		coreRequest <= 1'b0;
		axiWr(`LPM_OFF_DYNREF, 32'h00000C88);
		waitSt(6'h01, 10);
		repeat (5) @(negedge clk);
		chkS(6'h01);
		$display("test selfref done");
		// Precharge sleep after one timeout unit; three exit causes
		axiWr(`LPM_OFF_TIMEOUT, 32'h00000001);
		axiWr(`LPM_OFF_SLEEP, 32'h00000002);
		for (k = 0; k < 3; k++) begin
			waitSt(6'h04, 80);
			if (k == 0)
				chkW("prechgWait", 32'h1, {31'h0, c >= 30 && c <= 36});
			chkW("ioCke", 32'h0, {30'h0, memIoEnable, memCke});
			@(posedge clk);
			refKick <= (k == 0);
			coreRequest <= (k == 1);
			@(posedge clk);
			refKick <= 1'b0;
			coreRequest <= 1'b0;
			if (k == 2)
				axiWr(`LPM_OFF_SLEEP, 32'h00000000);
			waitSt(6'h01, 8);
			chkS(6'h01);
		end
		$display("test precharge done");
		// Deep sleep, data lost, reinit on disallow
		axiWr(`LPM_OFF_SLEEP, 32'h00000001);
		waitSt(6'h08, 10);
		chkS(6'h08);
		rdChk(`LPM_OFF_STATUS, 32'h00000108);
		axiWr(`LPM_OFF_SLEEP, 32'h00000000);
		waitSt(6'h20, 4);
		waitSt(6'h01, 300);
		chkW("reinitLen", 32'h1, {31'h0, c >= 64});
		rdChk(`LPM_OFF_STATUS, 32'h00000001);
		$display("test deep done");
		// Other memory type refuses deep sleep and clock halt
		axiWr(`LPM_OFF_MEMTYPE, 32'h00000000);
		axiWr(`LPM_OFF_SLEEP, 32'h00000001);
		axiWr(`LPM_OFF_PWRSAVE, 32'h00000415);
		repeat (10) @(negedge clk);
		chkS(6'h01);
		axiWr(`LPM_OFF_SLEEP, 32'h00000000);
		axiWr(`LPM_OFF_MEMTYPE, 32'h00000001);
		waitSt(6'h10, 10);
		chkW("memClk", 32'h0, {31'h0, memClkEnable});
		axiWr(`LPM_OFF_PWRSAVE, 32'h00000414);
		waitSt(6'h01, 10);
		chkS(6'h01);
		$display("test clkhalt done");
		// Random allow patterns while busy never sleep
		for (k = 0; k < 20; k++) begin
			@(posedge clk);
			opsPending <= 1'b1;
			v = $urandom % 4;
			axiWr(`LPM_OFF_SLEEP, v);
			rdChk(`LPM_OFF_SLEEP, v);
			axiWr(`LPM_OFF_PWRSAVE, 32'h00000414 | ($urandom % 2));
			repeat ($urandom % 8) @(negedge clk);
			chkS(6'h01);
			axiWr(`LPM_OFF_SLEEP, 32'h00000000);
			axiWr(`LPM_OFF_PWRSAVE, 32'h00000414);
		end
		$display("test random done");
		conclude;
	end
endmodule
